// ===== include/ptsr_pkg.sv
package ptsr_pkg;

  // ------------------------------------------------------------------
  // register map
  // ------------------------------------------------------------------
  localparam int         REG_COUNT        = 7;
  localparam int         ADDR_WIDTH       = 10;
  localparam int         DATA_WIDTH       = 16;
  localparam int         CORE_COUNT       = 4;

  localparam logic [9:0] HS_DS_OFFSET     = 10'h18A;
  localparam logic [9:0] HS_SRC_OFFSET    = 10'h18B;
  localparam logic [9:0] LS_DS_A_OFFSET   = 10'h18C;
  localparam logic [9:0] LS_DS_B_OFFSET   = 10'h18D;
  localparam logic [9:0] HS_RATE_OFFSET   = 10'h18E;
  localparam logic [9:0] LS_RATE_OFFSET   = 10'h18F;
  localparam logic [9:0] BOOST_OFFSET     = 10'h19D;

  // register index inside the bank
  typedef enum logic [2:0] {
    REG_HS_DS   = 3'h0,
    REG_HS_SRC  = 3'h1,
    REG_LS_DS_A = 3'h2,
    REG_LS_DS_B = 3'h3,
    REG_HS_RATE = 3'h4,
    REG_LS_RATE = 3'h5,
    REG_BOOST   = 3'h6
  } ptsr_reg_type;

  // ------------------------------------------------------------------
  // field layout
  // ------------------------------------------------------------------
  localparam int         LIMIT_WIDTH      = 3;
  localparam int         RATE_WIDTH       = 2;
  localparam int         HS_COUNT         = 5;
  localparam int         LS_A_COUNT       = 5;
  localparam int         LS_RATE_COUNT    = 6;
  localparam int         DCDC_FALL_LSB    = 12;
  localparam int         DCDC_RISE_LSB    = 14;
  localparam int         FILTER_CNT_WIDTH = 12;
  localparam int         FILTER_POLICY_BIT = 12;

  // grant map bit positions: hs1..hs5, ls1..ls6, then the dc-dc driver
  localparam int         GRANT_WIDTH      = 12;
  localparam int         HS_GRANT_BASE    = 0;
  localparam int         LS_GRANT_BASE    = 5;
  localparam int         LS6_GRANT        = 10;
  localparam int         DCDC_GRANT       = 11;

  // ------------------------------------------------------------------
  // writable bits and reset values, by bank index
  // ------------------------------------------------------------------
  localparam logic [15:0] HS_LIMITS_MASK  = 16'h7FFF;
  localparam logic [15:0] LS_B_MASK       = 16'h0007;
  localparam logic [15:0] HS_RATE_MASK    = 16'h03FF;
  localparam logic [15:0] LS_RATE_MASK    = 16'hFFFF;
  localparam logic [15:0] BOOST_MASK      = 16'h1FFF;
  localparam logic [15:0] DCDC_RATE_MASK  = 16'hF000;
  localparam logic [15:0] ZERO_RESET      = 16'h0000;
  localparam logic [15:0] BOOST_RESET     = 16'h0001;

  localparam logic [9:0] OFFSET [REG_COUNT] = '{
    HS_DS_OFFSET, HS_SRC_OFFSET, LS_DS_A_OFFSET, LS_DS_B_OFFSET,
    HS_RATE_OFFSET, LS_RATE_OFFSET, BOOST_OFFSET};

  localparam logic [15:0] VALID_MASK [REG_COUNT] = '{
    HS_LIMITS_MASK, HS_LIMITS_MASK, HS_LIMITS_MASK, LS_B_MASK,
    HS_RATE_MASK, LS_RATE_MASK, BOOST_MASK};

  localparam logic [15:0] RESET_VALUE [REG_COUNT] = '{
    ZERO_RESET, ZERO_RESET, ZERO_RESET, ZERO_RESET,
    ZERO_RESET, ZERO_RESET, BOOST_RESET};

  // only the boost filter register carries lockable fields
  localparam logic [REG_COUNT-1:0] LOCKABLE = 7'h40;

endpackage

// ===== core/ptsr_deglitch.sv
module ptsr_deglitch
  import ptsr_pkg::*;
(
  input  wire logic                        clock,
  input  wire logic                        rst_n,
  input  wire logic                        sample,
  input  wire logic                        policy,
  input  wire logic [FILTER_CNT_WIDTH-1:0] limit,
  output logic                             filtered
);

  // ------------------------------------------------------------------
  // counter
  // ------------------------------------------------------------------
  logic [FILTER_CNT_WIDTH-1:0] count;
  logic [FILTER_CNT_WIDTH-1:0] next_count;
  logic                        next_filtered;
  logic                        differs;
  logic                        at_limit;

  assign differs  = sample != filtered;
  // >= so that lowering the limit mid-count cannot strand the counter
  assign at_limit = count >= limit;

  // a run of limit+1 differing samples flips the output
  always_comb begin
    next_filtered = filtered;
    next_count    = count;
    if (differs) begin
      if (at_limit) begin
        next_filtered = ~filtered;
        next_count    = '0;
      end else begin
        next_count = count + 1'b1;
      end
    end else if (policy) begin
      // tolerant mode: an agreeing sample only backs off by one
      if (count != '0) begin
        next_count = count - 1'b1;
      end
    end else begin
      next_count = '0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count    <= '0;
      filtered <= 1'b0;
    end else begin
      count    <= next_count;
      filtered <= next_filtered;
    end
  end

endmodule // ptsr_deglitch

// ===== core/ptsr_regs.sv
module ptsr_regs
  import ptsr_pkg::*;
(
  input  wire logic                                   clock,
  input  wire logic                                   rst_n,
  input  wire logic                                   spi_wr_en,
  input  wire logic                                   spi_rd_en,
  input  wire logic [ADDR_WIDTH-1:0]                  spi_addr,
  input  wire logic [DATA_WIDTH-1:0]                  spi_wdata,
  output logic      [DATA_WIDTH-1:0]                  spi_rdata,
  input  wire logic [CORE_COUNT-1:0]                  uc_wr_en,
  input  wire logic [CORE_COUNT-1:0][ADDR_WIDTH-1:0]  uc_addr,
  input  wire logic [CORE_COUNT-1:0][DATA_WIDTH-1:0]  uc_wdata,
  input  wire logic [CORE_COUNT-1:0][GRANT_WIDTH-1:0] output_grant_map,
  input  wire logic [CORE_COUNT-1:0]                  boost_dac_grant,
  input  wire logic                                   lock_active,
  input  wire logic [HS_COUNT-1:0]                    hs_src_override_en,
  input  wire logic [HS_COUNT-1:0][LIMIT_WIDTH-1:0]   hs_src_override_code,
  input  wire logic                                   boost_cmp_raw,
  output logic                                        boost_fbk_filtered,
  output logic      [HS_COUNT-1:0][LIMIT_WIDTH-1:0]   hs_drain_source_limit_code,
  output logic      [HS_COUNT-1:0][LIMIT_WIDTH-1:0]   hs_source_limit_code,
  output logic      [5:0][LIMIT_WIDTH-1:0]            ls_drain_source_limit_code,
  output logic      [HS_COUNT-1:0][RATE_WIDTH-1:0]    hs_edge_rate_code,
  output logic      [5:0][RATE_WIDTH-1:0]             ls_edge_rate_code,
  output logic      [RATE_WIDTH-1:0]                  dcdc_rise_rate_code,
  output logic      [RATE_WIDTH-1:0]                  dcdc_fall_rate_code
);

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------

  // bank index for an address; bit 3 flags a hit
  function automatic logic [3:0] decode(input logic [ADDR_WIDTH-1:0] a);
    logic [3:0] d;
    d = 4'h0;
    for (int r = 0; r < REG_COUNT; r++) begin
      if (a == OFFSET[r]) begin
        d = {1'b1, 3'(r)};
      end
    end
    return d;
  endfunction

  // bits of register r that one microcore may change
  function automatic logic [15:0] core_mask(
    input logic [2:0]             r,
    input logic [GRANT_WIDTH-1:0] g,
    input logic                   bg
  );
    logic [15:0] m;
    m = '0;
    case (r)
      REG_HS_DS, REG_HS_SRC: begin
        for (int i = 0; i < HS_COUNT; i++) begin
          if (g[HS_GRANT_BASE+i]) begin
            m[LIMIT_WIDTH*i +: LIMIT_WIDTH] = '1;
          end
        end
      end
      REG_LS_DS_A: begin
        for (int i = 0; i < LS_A_COUNT; i++) begin
          if (g[LS_GRANT_BASE+i]) begin
            m[LIMIT_WIDTH*i +: LIMIT_WIDTH] = '1;
          end
        end
      end
      REG_LS_DS_B: begin
        if (g[LS6_GRANT]) begin
          m = LS_B_MASK;
        end
      end
      REG_HS_RATE: begin
        for (int i = 0; i < HS_COUNT; i++) begin
          if (g[HS_GRANT_BASE+i]) begin
            m[RATE_WIDTH*i +: RATE_WIDTH] = '1;
          end
        end
      end
      REG_LS_RATE: begin
        for (int i = 0; i < LS_RATE_COUNT; i++) begin
          if (g[LS_GRANT_BASE+i]) begin
            m[RATE_WIDTH*i +: RATE_WIDTH] = '1;
          end
        end
        if (g[DCDC_GRANT]) begin
          m = m | DCDC_RATE_MASK;
        end
      end
      REG_BOOST: begin
        if (bg) begin
          m = BOOST_MASK;
        end
      end
      default: m = '0;
    endcase
    return m;
  endfunction

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  logic [15:0]                bank      [REG_COUNT];
  logic [15:0]                next_bank [REG_COUNT];
  logic [3:0]                 spi_dec;
  logic                       spi_hit;
  logic [2:0]                 spi_idx;
  logic [CORE_COUNT-1:0][3:0] uc_dec;
  logic [REG_COUNT-1:0]       reg_locked;

  assign spi_dec      = decode(spi_addr);
  assign spi_hit      = spi_dec[3];
  assign spi_idx      = spi_dec[2:0];
  assign reg_locked   = LOCKABLE & {REG_COUNT{lock_active}};

  for (genvar c = 0; c < CORE_COUNT; c++) begin : g_core_dec
    assign uc_dec[c] = decode(uc_addr[c]);
  end

  // ------------------------------------------------------------------
  // write merge
  // ------------------------------------------------------------------

  // microcores first, in index order, then the host, so the host wins a
  // field that both touch in the same cycle
  always_comb begin
    for (int r = 0; r < REG_COUNT; r++) begin
      next_bank[r] = bank[r];
      for (int c = 0; c < CORE_COUNT; c++) begin
        if (uc_wr_en[c] && uc_dec[c] == {1'b1, 3'(r)} &&
            !reg_locked[r]) begin
          next_bank[r] = (next_bank[r] &
                          ~core_mask(3'(r), output_grant_map[c],
                                     boost_dac_grant[c])) |
                         (uc_wdata[c] &
                          core_mask(3'(r), output_grant_map[c],
                                    boost_dac_grant[c]));
        end
      end
      // host owns every field; reserved bits are never stored
      if (spi_wr_en && spi_dec == {1'b1, 3'(r)} &&
          !reg_locked[r]) begin
        next_bank[r] = spi_wdata & VALID_MASK[r];
      end
    end
  end

  // all fields reset to zero except the boost count, which starts at one
  always_ff @(posedge clock) begin
    for (int r = 0; r < REG_COUNT; r++) begin
      if (!rst_n) begin
        bank[r] <= RESET_VALUE[r];
      end else begin
        bank[r] <= next_bank[r];
      end
    end
  end

  // ------------------------------------------------------------------
  // bootstrap override of the high-side source thresholds
  // ------------------------------------------------------------------
  logic [HS_COUNT-1:0][LIMIT_WIDTH-1:0] next_src_applied;
  logic [15:0]                          src_applied_word;

  for (genvar i = 0; i < HS_COUNT; i++) begin : g_src
    // override only where init is active, else the stored code
    assign next_src_applied[i] = hs_src_override_en[i] ?
        hs_src_override_code[i] :
        bank[REG_HS_SRC][LIMIT_WIDTH*i +: LIMIT_WIDTH];
  end

  assign src_applied_word = {1'b0, next_src_applied};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hs_source_limit_code <= '0;
    end else begin
      hs_source_limit_code <= next_src_applied;
    end
  end

  // ------------------------------------------------------------------
  // host readback
  // ------------------------------------------------------------------
  logic [15:0] rd_value;

  // source thresholds read back what the monitors really see
  assign rd_value = (spi_idx == REG_HS_SRC) ? src_applied_word :
                    bank[spi_idx] & VALID_MASK[spi_idx];

  // one-cycle latency; unmapped addresses read as zero
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      spi_rdata <= '0;
    end else if (spi_rd_en) begin
      spi_rdata <= spi_hit ? rd_value : 16'h0000;
    end
  end

  // ------------------------------------------------------------------
  // codes to the analog side
  // ------------------------------------------------------------------

  // straight bank bits: no logic between flop and pin
  for (genvar i = 0; i < HS_COUNT; i++) begin : g_hs_out
    assign hs_drain_source_limit_code[i] =
        bank[REG_HS_DS][LIMIT_WIDTH*i +: LIMIT_WIDTH];
    assign hs_edge_rate_code[i] =
        bank[REG_HS_RATE][RATE_WIDTH*i +: RATE_WIDTH];
  end

  for (genvar i = 0; i < LS_A_COUNT; i++) begin : g_ls_out
    assign ls_drain_source_limit_code[i] =
        bank[REG_LS_DS_A][LIMIT_WIDTH*i +: LIMIT_WIDTH];
  end

  assign ls_drain_source_limit_code[5] =
      bank[REG_LS_DS_B][LIMIT_WIDTH-1:0];

  for (genvar i = 0; i < LS_RATE_COUNT; i++) begin : g_ls_rate
    // one code drives both edges of each ordinary driver
    assign ls_edge_rate_code[i] =
        bank[REG_LS_RATE][RATE_WIDTH*i +: RATE_WIDTH];
  end

  // dc-dc driver alone has split edge codes
  assign dcdc_fall_rate_code =
      bank[REG_LS_RATE][DCDC_FALL_LSB +: RATE_WIDTH];
  assign dcdc_rise_rate_code =
      bank[REG_LS_RATE][DCDC_RISE_LSB +: RATE_WIDTH];

  // ------------------------------------------------------------------
  // boost comparator deglitch
  // ------------------------------------------------------------------
  ptsr_deglitch u_deglitch (
    .clock    (clock),
    .rst_n    (rst_n),
    .sample   (boost_cmp_raw),
    .policy   (bank[REG_BOOST][FILTER_POLICY_BIT]),
    .limit    (bank[REG_BOOST][FILTER_CNT_WIDTH-1:0]),
    .filtered (boost_fbk_filtered)
  );

endmodule // ptsr_regs

// ===== tb/ptsr_chk.sv
module ptsr_chk
  import ptsr_pkg::*;
(
  input wire logic                                   clock,
  input wire logic                                   rst_n,
  input wire logic                                   spi_wr_en,
  input wire logic [ADDR_WIDTH-1:0]                  spi_addr,
  input wire logic [DATA_WIDTH-1:0]                  spi_wdata,
  input wire logic [CORE_COUNT-1:0]                  uc_wr_en,
  input wire logic [CORE_COUNT-1:0][ADDR_WIDTH-1:0]  uc_addr,
  input wire logic [CORE_COUNT-1:0][GRANT_WIDTH-1:0] output_grant_map,
  input wire logic [HS_COUNT-1:0]                    hs_src_override_en,
  input wire logic [HS_COUNT-1:0][LIMIT_WIDTH-1:0]   hs_src_override_code,
  input wire logic                                   boost_cmp_raw,
  input wire logic                                   boost_fbk_filtered,
  input wire logic [HS_COUNT-1:0][LIMIT_WIDTH-1:0]   hs_drain_source_limit_code,
  input wire logic [HS_COUNT-1:0][LIMIT_WIDTH-1:0]   hs_source_limit_code,
  input wire logic [5:0][LIMIT_WIDTH-1:0]            ls_drain_source_limit_code,
  input wire logic [HS_COUNT-1:0][RATE_WIDTH-1:0]    hs_edge_rate_code,
  input wire logic [5:0][RATE_WIDTH-1:0]             ls_edge_rate_code,
  input wire logic [RATE_WIDTH-1:0]                  dcdc_rise_rate_code,
  input wire logic [RATE_WIDTH-1:0]                  dcdc_fall_rate_code
);
  // ------------------------------------------------------------------
  // port relations
  // ------------------------------------------------------------------
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // sample agrees with the filtered state
  sequence s_agree;
    boost_cmp_raw == boost_fbk_filtered;
  endsequence

  // host write visible one cycle later; host beats every core
  a_hs_rate_write: assert property (
    spi_wr_en && spi_addr == HS_RATE_OFFSET
    |=> hs_edge_rate_code == $past(spi_wdata[9:0]))
    else $error("hs edge rate code not taken");
  a_ls_rate_write: assert property (
    spi_wr_en && spi_addr == LS_RATE_OFFSET
    |=> {dcdc_rise_rate_code, dcdc_fall_rate_code,
         ls_edge_rate_code} == $past(spi_wdata))
    else $error("ls edge rate codes not taken");
  a_hs_ds_write: assert property (
    spi_wr_en && spi_addr == HS_DS_OFFSET
    |=> hs_drain_source_limit_code == $past(spi_wdata[14:0]))
    else $error("hs drain source codes not taken");
  a_ls_six_write: assert property (
    spi_wr_en && spi_addr == LS_DS_B_OFFSET
    |=> ls_drain_source_limit_code[5] == $past(spi_wdata[2:0]))
    else $error("ls six code not taken");
  a_ls_ds_write: assert property (
    spi_wr_en && spi_addr == LS_DS_A_OFFSET
    |=> ls_drain_source_limit_code[4:0] == $past(spi_wdata[14:0]))
    else $error("ls drain source codes not taken");
  a_override_applied: assert property (
    $past(hs_src_override_en[0])
    |-> hs_source_limit_code[0] == $past(hs_src_override_code[0]))
    else $error("override code not applied");
  a_codes_hold: assert property (
    !spi_wr_en && uc_wr_en == 4'h0
    |=> $stable(hs_drain_source_limit_code))
    else $error("codes moved without a write");
  a_grant_blocks: assert property (
    uc_wr_en == 4'h2 && !spi_wr_en && uc_addr[1] == HS_DS_OFFSET
    && output_grant_map[1] == 12'h000
    |=> $stable(hs_drain_source_limit_code))
    else $error("ungranted core write landed");
  a_filter_agree: assert property (
    s_agree |=> $stable(boost_fbk_filtered))
    else $error("filter flipped on agreeing sample");
endmodule // ptsr_chk

bind ptsr_regs ptsr_chk u_chk (
  .clock(clock), .rst_n(rst_n), .spi_wr_en(spi_wr_en),
  .spi_addr(spi_addr), .spi_wdata(spi_wdata), .uc_wr_en(uc_wr_en),
  .uc_addr(uc_addr), .output_grant_map(output_grant_map),
  .hs_src_override_en(hs_src_override_en),
  .hs_src_override_code(hs_src_override_code),
  .boost_cmp_raw(boost_cmp_raw), .boost_fbk_filtered(boost_fbk_filtered),
  .hs_drain_source_limit_code(hs_drain_source_limit_code),
  .hs_source_limit_code(hs_source_limit_code),
  .ls_drain_source_limit_code(ls_drain_source_limit_code),
  .hs_edge_rate_code(hs_edge_rate_code),
  .ls_edge_rate_code(ls_edge_rate_code),
  .dcdc_rise_rate_code(dcdc_rise_rate_code),
  .dcdc_fall_rate_code(dcdc_fall_rate_code));

// ===== tb/ptsr_host_model.sv
module ptsr_host_model
  import ptsr_pkg::*;
(
  input  wire logic                                  clock,
  output logic                                       spi_wr_en,
  output logic                                       spi_rd_en,
  output logic      [ADDR_WIDTH-1:0]                 spi_addr,
  output logic      [DATA_WIDTH-1:0]                 spi_wdata,
  input  wire logic [DATA_WIDTH-1:0]                 spi_rdata,
  output logic      [CORE_COUNT-1:0]                 uc_wr_en,
  output logic      [CORE_COUNT-1:0][ADDR_WIDTH-1:0] uc_addr,
  output logic      [CORE_COUNT-1:0][DATA_WIDTH-1:0] uc_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------------
  // host and microcore requesters
  // ------------------------------------------------------------------
  initial begin
    spi_wr_en = 1'b0;
    spi_rd_en = 1'b0;
    spi_addr  = 10'h000;
    spi_wdata = 16'h0000;
    uc_wr_en  = 4'h0;
    uc_addr   = '0;
    uc_wdata  = '0;
  end

  // idle edge first so strobes never toggle twice in one step;
  // released buses show the inverse so stale data is never trusted
  task automatic spi_write(input logic [9:0] a, input logic [15:0] d);
    @(posedge clock);
    #1;
    spi_wr_en = 1'b1;
    spi_addr  = a;
    spi_wdata = d;
    @(posedge clock);
    #1;
    spi_wr_en = 1'b0;
    spi_addr  = ~a;
    spi_wdata = ~d;
  endtask

  task automatic spi_read(input logic [9:0] a, output logic [15:0] d);
    @(posedge clock);
    #1;
    spi_rd_en = 1'b1;
    spi_addr  = a;
    @(posedge clock);
    #1;
    spi_rd_en = 1'b0;
    spi_addr  = ~a;
    d         = spi_rdata;
  endtask

  task automatic uc_write(input int c, input logic [9:0] a,
                          input logic [15:0] d);
    @(posedge clock);
    #1;
    uc_wr_en[c] = 1'b1;
    uc_addr[c]  = a;
    uc_wdata[c] = d;
    @(posedge clock);
    #1;
    uc_wr_en[c] = 1'b0;
    uc_addr[c]  = ~a;
    uc_wdata[c] = ~d;
  endtask
endmodule // ptsr_host_model

// ===== tb/predriver_threshold_slew_regs_test.sv
module predriver_threshold_slew_regs_test
  import ptsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ------------------------------------------------------------------
  // bench signals
  // ------------------------------------------------------------------
  logic                                   clock = 1'b0;
  logic                                   rst_n = 1'b0;
  logic [CORE_COUNT-1:0][GRANT_WIDTH-1:0] grant = '0;
  logic [CORE_COUNT-1:0]                  bgrant = 4'h0;
  logic                                   lock = 1'b0;
  logic [HS_COUNT-1:0]                    ov_en = 5'h00;
  logic [HS_COUNT-1:0][LIMIT_WIDTH-1:0]   ov_code = '0;
  logic                                   raw = 1'b0;
  int                                     errors = 0;
  int                                     check_count = 0;
  wire logic                              wr, rd, filt;
  wire logic [ADDR_WIDTH-1:0]             addr;
  wire logic [DATA_WIDTH-1:0]             wdata, rdata;
  wire logic [CORE_COUNT-1:0]             uwr;
  wire logic [CORE_COUNT-1:0][ADDR_WIDTH-1:0] uaddr;
  wire logic [CORE_COUNT-1:0][DATA_WIDTH-1:0] udata;

  always #5 clock = ~clock;

  ptsr_host_model hm (.clock(clock), .spi_wr_en(wr), .spi_rd_en(rd),
    .spi_addr(addr), .spi_wdata(wdata), .spi_rdata(rdata),
    .uc_wr_en(uwr), .uc_addr(uaddr), .uc_wdata(udata));

  ptsr_regs dut (.clock(clock), .rst_n(rst_n), .spi_wr_en(wr),
    .spi_rd_en(rd), .spi_addr(addr), .spi_wdata(wdata),
    .spi_rdata(rdata), .uc_wr_en(uwr), .uc_addr(uaddr),
    .uc_wdata(udata), .output_grant_map(grant),
    .boost_dac_grant(bgrant), .lock_active(lock),
    .hs_src_override_en(ov_en), .hs_src_override_code(ov_code),
    .boost_cmp_raw(raw), .boost_fbk_filtered(filt),
    .hs_drain_source_limit_code(), .hs_source_limit_code(),
    .ls_drain_source_limit_code(), .hs_edge_rate_code(),
    .ls_edge_rate_code(), .dcdc_rise_rate_code(),
    .dcdc_fall_rate_code());

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [9:0] a, input logic [15:0] exp);
    logic [15:0] d;
    hm.spi_read(a, d);
    chk(d, exp);
  endtask

  // comparator level held for n sampling edges
  task automatic hold(input logic v, input int n);
    raw = v;
    repeat (n) begin
      @(posedge clock);
      #1;
    end
  endtask

  task automatic end_of_test;
    $display("errors %0d, checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic t_reset;
    for (int i = 0; i < REG_COUNT; i++)
      rd_chk(OFFSET[i], RESET_VALUE[i]);
    rd_chk(10'h190, 16'h0000);
  endtask

  // two patterns show reserved bits drop and fields stand alone
  task automatic t_fields;
    logic [15:0] p [2] = '{16'hFFFF, 16'h5A5A};
    foreach (p[k]) begin
      for (int i = 0; i < REG_COUNT; i++)
        hm.spi_write(OFFSET[i], p[k]);
      for (int i = 0; i < REG_COUNT; i++)
        rd_chk(OFFSET[i], p[k] & VALID_MASK[i]);
    end
  endtask

  task automatic t_grant;
    hm.spi_write(HS_DS_OFFSET, 16'h0000);
    hm.uc_write(1, HS_DS_OFFSET, 16'h7FFF);
    rd_chk(HS_DS_OFFSET, 16'h0000);
    grant[1] = 12'h002;
    hm.uc_write(1, HS_DS_OFFSET, 16'h7FFF);
    rd_chk(HS_DS_OFFSET, 16'h0038);
    hm.spi_write(BOOST_OFFSET, 16'h0003);
    hm.uc_write(2, BOOST_OFFSET, 16'h0005);
    rd_chk(BOOST_OFFSET, 16'h0003);
    bgrant = 4'h4;
    hm.uc_write(2, BOOST_OFFSET, 16'h0005);
    rd_chk(BOOST_OFFSET, 16'h0005);
    lock = 1'b1;
    hm.uc_write(2, BOOST_OFFSET, 16'h0007);
    rd_chk(BOOST_OFFSET, 16'h0005);
    hm.spi_write(BOOST_OFFSET, 16'h0009);
    rd_chk(BOOST_OFFSET, 16'h0005);
    lock = 1'b0;
  endtask

  task automatic t_override;
    hm.spi_write(HS_SRC_OFFSET, 16'h1249);
    ov_code[0] = 3'h6;
    ov_en = 5'h01;
    hold(1'b0, 2);
    rd_chk(HS_SRC_OFFSET, 16'h124E);
    ov_en = 5'h00;
    hold(1'b0, 2);
    rd_chk(HS_SRC_OFFSET, 16'h1249);
  endtask

  // count 3: a flip needs four differing samples, in a row unless tolerant
  task automatic t_filter;
    hm.spi_write(BOOST_OFFSET, 16'h0003);
    hold(1'b1, 3);
    hold(1'b0, 1);
    hold(1'b1, 3);
    chk({15'h0000, filt}, 16'h0000);
    hold(1'b1, 1);
    chk({15'h0000, filt}, 16'h0001);
    hm.spi_write(BOOST_OFFSET, 16'h1003);
    hold(1'b0, 3);
    hold(1'b1, 1);
    hold(1'b0, 1);
    chk({15'h0000, filt}, 16'h0001);
    hold(1'b0, 1);
    chk({15'h0000, filt}, 16'h0000);
  endtask

  initial begin
    #100000;
    errors++;
    end_of_test;
  end

  initial begin
    repeat (20) @(posedge clock);
    #1;
    rst_n = 1'b1;
    t_reset;
    t_fields;
    t_grant;
    t_override;
    t_filter;
    end_of_test;
  end
endmodule // predriver_threshold_slew_regs_test
